// >>> src/sbsc_consts.svh
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH
// Widths of the pin groups and the number of words in the array.
`define SBSC_ADDR_W   18
`define SBSC_DATA_W   16
`define SBSC_PAR_W    2
`define SBSC_WORDS    262144
// Reset values of the control flops.
`define SBSC_RST_ADDR 18'h00000
`define SBSC_RST_DATA 16'h0000
`define SBSC_RST_PAR  2'h0
// Pad pull defaults: snooze pulls low, burst order pulls high.
`define SBSC_SNOOZE_DEF 1'b0
`define SBSC_ORDER_DEF  1'b1
// Flops between an asynchronous pin and the logic.
`define SBSC_SYNC_STAGES 2
`endif

// >>> src/sbsc_pkg.sv
`include "sbsc_consts.svh"
package sbsc_pkg;
    // Power state of the memory, one-hot.
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h1,
        PWR_SLEEP  = 2'h2
    } sbsc_pwr_e;
    typedef logic [`SBSC_ADDR_W-1:0] sbsc_addr_t;
endpackage : sbsc_pkg

// >>> src/sbsc_pin_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbsc_consts.svh"

// What this block does
// R01: Second chip select active high, sampled each edge.
// R02: Third chip select active low, sampled each edge.
// R03: Selected only when first low, second high, third low.
// R04: Output enable low drives data and parity pins.
// R05: Output enable high releases pins as inputs.
// R06: Detected write releases data pins regardless.
// R07: Sixteen data lines captured on rising edge.
// R08: Read returns word at previously captured address.
// R09: Parity lines follow data, one per byte.
// R10: Snooze high: standby, ignore inputs, keep array.
// R11: Unconnected snooze reads low, stays active.
// R12: Burst order high interleaved, low linear, default interleaved.
// R13: All synchronous inputs captured on rising edge only.
// R14: Controller raises output enable while driving writes.
module sbsc_pin_control (
    // Clock and reset.
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    // Chip selects.
    input  wire logic                    chipSelFirst_n,
    input  wire logic                    chipSelSecond,
    input  wire logic                    chipSelThird_n,
    // Asynchronous pins.
    input  wire logic                    outEnable_n,
    input  wire logic                    snoozeReq,
    input  wire logic                    burstOrderSel,
    // From the strobe and write logic of the memory.
    input  wire logic                    addrLoad,
    input  wire logic                    writeDetect,
    input  wire logic [1:0]              byteWrite,
    input  wire logic [`SBSC_ADDR_W-1:0] address,
    // Data pins.
    input  wire logic [`SBSC_DATA_W-1:0] dataIn,
    output var  logic [`SBSC_DATA_W-1:0] dataOut,
    output var  logic                    dataOe,
    // Parity pins.
    input  wire logic [`SBSC_PAR_W-1:0]  parityIn,
    output var  logic [`SBSC_PAR_W-1:0]  parityOut,
    output var  logic                    parityOe,
    // Status.
    output var  logic                    chipSelected,
    output var  logic                    interleaveMode,
    output var  logic                    sleepActive
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic                    oeMeta;
    logic                    oeSync;
    logic                    snzMeta;
    logic                    snzSync;
    logic                    ordMeta;
    logic                    ordSync;
    sbsc_pkg::sbsc_pwr_e     pwrState;
    sbsc_pkg::sbsc_addr_t    addrReg;
    logic [`SBSC_DATA_W-1:0] dataReg;
    logic [`SBSC_PAR_W-1:0]  parReg;
    logic [1:0]              wrPend;
    sbsc_pkg::sbsc_addr_t    wrAddr;
    logic                    readValid;
    logic                    selNow;
    logic                    awake;
    logic [17:0]             rdWord;

    // Output enable and mode pins pass two flops; pull defaults at reset.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            oeMeta  <= 1'b1;
            oeSync  <= 1'b1;
            ordMeta <= `SBSC_ORDER_DEF;
            ordSync <= `SBSC_ORDER_DEF;
        end else begin
            oeMeta  <= outEnable_n;
            oeSync  <= oeMeta;
            ordMeta <= burstOrderSel;
            ordSync <= ordMeta;
        end
    end

    // Snooze synchroniser; the two flops give the two-cycle entry delay.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            snzMeta <= `SBSC_SNOOZE_DEF; // [R11]
            snzSync <= `SBSC_SNOOZE_DEF;
        end else begin
            snzMeta <= snoozeReq;
            snzSync <= snzMeta;
        end
    end

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    // A floating snooze pin is resolved low by its pad pull.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pwrState <= sbsc_pkg::PWR_ACTIVE; // [R11]
        end else begin
            case (pwrState)
                sbsc_pkg::PWR_ACTIVE: begin
                    if (snzSync) begin
                        pwrState <= sbsc_pkg::PWR_SLEEP; // [R10]
                    end
                end
                sbsc_pkg::PWR_SLEEP: begin
                    if (!snzSync) begin
                        pwrState <= sbsc_pkg::PWR_ACTIVE;
                    end
                end
                default: begin
                    pwrState <= sbsc_pkg::PWR_ACTIVE;
                end
            endcase
        end
    end

    // Inputs count only while awake and not about to sleep.
    assign awake  = (pwrState == sbsc_pkg::PWR_ACTIVE) && !snzSync;
    assign selNow = !chipSelFirst_n && chipSelSecond
                    && !chipSelThird_n; // [R01] [R02] [R03]

    // ------------------------------------------------------------
    // Address, data and parity capture
    // ------------------------------------------------------------
    // Address register loads only for a selected, strobed cycle.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addrReg      <= `SBSC_RST_ADDR;
            chipSelected <= 1'b0;
        end else if (awake) begin
            chipSelected <= selNow; // [R13]
            if (selNow && addrLoad) begin
                addrReg <= address; // [R08]
            end
        end
    end

    // Data and parity inputs share one register stage.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dataReg <= `SBSC_RST_DATA;
            parReg  <= `SBSC_RST_PAR;
        end else if (awake) begin
            dataReg <= dataIn;   // [R07] [R13]
            parReg  <= parityIn; // [R09]
        end
    end

    // Write is taken on the detect edge, committed one edge later.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wrPend <= 2'h0;
            wrAddr <= `SBSC_RST_ADDR;
        end else if (awake && writeDetect) begin
            wrPend <= byteWrite;
            wrAddr <= addrReg;
        end else begin
            wrPend <= 2'h0;
        end
    end

    // Each byte lane carries its own parity bit into the array.
    // Every lane owns its array, so no two processes write one variable.
    genvar gb;
    generate
        for (gb = 0; gb < 2; gb = gb + 1) begin : g_lane
            logic [8:0] laneMem [0:`SBSC_WORDS-1];
            always_ff @(posedge clk_sys) begin
                if (wrPend[gb]) begin
                    laneMem[wrAddr] <=
                        {parReg[gb], dataReg[gb*8 +: 8]}; // [R09]
                end
            end
            // Lane word as {parity, byte}; read by the output stage.
            assign rdWord[gb*9 +: 9] = laneMem[addrReg];
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path and pin direction
    // ------------------------------------------------------------
    // Sleep freezes the read outputs and blocks writes; contents stay as they are.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dataOut   <= `SBSC_RST_DATA;
            parityOut <= `SBSC_RST_PAR;
        end else if (awake) begin
            dataOut   <= {rdWord[16:9], rdWord[7:0]}; // [R08]
            parityOut <= {rdWord[17], rdWord[8]};     // [R09]
        end
    end

    // A read stays valid until a write, sleep or deselected load ends it.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            readValid <= 1'b0;
        end else if (!awake || writeDetect) begin
            readValid <= 1'b0;
        end else if (addrLoad) begin
            readValid <= selNow;
        end
    end

    // Direction follows output enable, but a write always releases.
    // The enable is synchronised, so it lags the pin by two edges.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dataOe   <= 1'b0;
            parityOe <= 1'b0;
        end else begin
            dataOe   <= !oeSync && readValid && awake
                        && !writeDetect; // [R04] [R05] [R06] [R10]
            parityOe <= !oeSync && readValid && awake
                        && !writeDetect; // [R09]
        end
    end

    // Mode pin; pull-up makes a floating pin interleaved.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            interleaveMode <= `SBSC_ORDER_DEF; // [R12]
            sleepActive    <= 1'b0;
        end else begin
            interleaveMode <= ordSync; // [R12]
            sleepActive    <= (pwrState == sbsc_pkg::PWR_SLEEP);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_write_releases: assert property ( // [R06]
        writeDetect |=> !dataOe && !parityOe)
        else $error("Pins driven after a write.");

    a_oe_high_release: assert property ( // [R05]
        oeSync |=> !dataOe)
        else $error("Pins driven with output enable high.");

    a_oe_low_drive: assert property ( // [R04]
        !oeSync && readValid && awake && !writeDetect |=> dataOe)
        else $error("Pins not driven on a read.");

    a_parity_follows: assert property ( // [R09]
        dataOe == parityOe)
        else $error("Parity direction differs from data.");

    a_select_decode: assert property ( // [R03]
        awake && !chipSelFirst_n && chipSelSecond && !chipSelThird_n
        |=> chipSelected)
        else $error("Select not seen.");

    a_second_low: assert property ( // [R01]
        awake && !chipSelSecond |=> !chipSelected)
        else $error("Selected with second select low.");

    a_third_high: assert property ( // [R02]
        awake && chipSelThird_n |=> !chipSelected)
        else $error("Selected with third select high.");

    a_addr_load: assert property ( // [R08]
        awake && selNow && addrLoad |=> addrReg == $past(address))
        else $error("Address not captured.");

    a_data_capture: assert property ( // [R07]
        awake |=> dataReg == $past(dataIn))
        else $error("Data not captured.");

    a_sleep_entry: assert property ( // [R10]
        snoozeReq [*3] |=> !dataOe ##1 sleepActive)
        else $error("Sleep not entered in time.");

    a_sleep_hold: assert property ( // [R10]
        !awake |=> $stable(addrReg) && $stable(dataReg))
        else $error("Input taken while asleep.");

    a_order_follow: assert property ( // [R12]
        burstOrderSel [*3] |=> interleaveMode)
        else $error("Burst order not followed.");

    a_order_linear: assert property ( // [R12]
        !burstOrderSel [*3] |=> !interleaveMode)
        else $error("Linear burst order not followed.");

    a_sel_hold: assert property ( // [R10]
        !awake |=> $stable(chipSelected))
        else $error("Select taken while asleep.");

    c_read_drive: cover property (readValid && !oeSync ##1 dataOe);
    c_write_release: cover property (dataOe ##1 writeDetect ##1 !dataOe);
    c_linear_mode: cover property (!interleaveMode ##1 interleaveMode);
    c_write_seen: cover property (writeDetect ##1 wrPend != 2'h0);
    c_sleep_cycle: cover property (sleepActive ##[1:20] !sleepActive);

endmodule : sbsc_pin_control
`default_nettype wire

// >>> sim/sbsc_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbsc_consts.svh"

// ----------------------------------------
// Cache controller on the far side of the data and parity lines
// ----------------------------------------
module sbsc_ctl_model (
    // Clock.
    input  wire logic        clk_sys,
    // Requests from the bench; ctlWord is {parity, data}.
    input  wire logic        oeReq,
    input  wire logic        ctlDrive,
    input  wire logic [17:0] ctlWord,
    // Memory side of the pins.
    input  wire logic [15:0] dataOut,
    input  wire logic        dataOe,
    input  wire logic [1:0]  parityOut,
    input  wire logic        parityOe,
    output var  logic        outEnable_n,
    output var  logic [15:0] dataIn,
    output var  logic [1:0]  parityIn
);
    logic [17:0] lastLevel = 18'h00000;

    // Enable is forced high while write data is driven, so both ends
    // never fight over the shared lines.
    always_comb begin
        outEnable_n = !oeReq || ctlDrive;
    end

    // Released lines have no pull, so they flip every cycle instead of
    // holding a stale value that could pass for good data.
    always_comb begin
        dataIn = dataOe ? dataOut :
                 (ctlDrive ? ctlWord[15:0] : ~lastLevel[15:0]);
        parityIn = parityOe ? parityOut :
                   (ctlDrive ? ctlWord[17:16] : ~lastLevel[17:16]);
    end

    // Remember the line levels of the last cycle.
    always_ff @(posedge clk_sys) begin
        lastLevel <= {parityIn, dataIn};
    end
endmodule : sbsc_ctl_model
`default_nettype wire

// >>> sim/test_sbsc_pin_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbsc_consts.svh"

module test_sbsc_pin_control;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk_sys, reset_n, chipSelFirst_n, chipSelSecond;
    logic        chipSelThird_n, snoozeReq, burstOrderSel, addrLoad;
    logic        writeDetect, oeReq, ctlDrive, outEnable_n, dataOe;
    logic        parityOe, chipSelected, interleaveMode, sleepActive;
    logic [1:0]  byteWrite, parityIn, parityOut;
    logic [17:0] address, ctlWord;
    logic [15:0] dataIn, dataOut;
    int          failures, checkCount;

    // Design and the controller that shares its pins.
    sbsc_pin_control uut (.clk_sys, .reset_n, .chipSelFirst_n,
        .chipSelSecond, .chipSelThird_n, .outEnable_n, .snoozeReq,
        .burstOrderSel, .addrLoad, .writeDetect, .byteWrite, .address,
        .dataIn, .dataOut, .dataOe, .parityIn, .parityOut, .parityOe,
        .chipSelected, .interleaveMode, .sleepActive);
    sbsc_ctl_model ctl (.clk_sys, .oeReq, .ctlDrive, .ctlWord,
        .dataOut, .dataOe, .parityOut, .parityOe, .outEnable_n,
        .dataIn, .parityIn);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Inputs always move 1 ns after an edge, away from sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic chk(input string nm, input logic [17:0] e,
                       input logic [17:0] g);
        checkCount++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic load(input logic [17:0] a);
        address = a;
        addrLoad = 1'b1;
        tick(1);
        addrLoad = 1'b0;
    endtask : load

    task automatic wr(input logic [17:0] a, w, input logic [1:0] bw);
        load(a);
        ctlWord = w;
        ctlDrive = 1'b1;
        writeDetect = 1'b1;
        byteWrite = bw;
        tick(1);
        ctlDrive = 1'b0;
        writeDetect = 1'b0;
        byteWrite = 2'h0;
        tick(1);
    endtask : wr

    // Read with enable low, then raise it and see the data pins let go.
    task automatic rd(input logic [17:0] a, w);
        oeReq = 1'b1;
        load(a);
        tick(4);
        chk("dataOut", {2'h0, w[15:0]}, {2'h0, dataOut});
        chk("parityOut", {16'h0, w[17:16]}, {16'h0, parityOut});
        chk("dataOe", 18'h00001, {17'h0, dataOe});
        chk("parityOe", 18'h00001, {17'h0, parityOe});
        oeReq = 1'b0;
        tick(4);
        chk("dataOe", 18'h00000, {17'h0, dataOe});
    endtask : rd

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Full write, lane-0 write over it, then a second address.
    task automatic t_rw;
        wr(18'h1F0A5, 18'h2A5C3, 2'h3);
        rd(18'h1F0A5, 18'h2A5C3);
        wr(18'h1F0A5, 18'h15A3C, 2'h1);
        wr(18'h00003, 18'h01234, 2'h3);
        rd(18'h1F0A5, 18'h3A53C);
    endtask : t_rw

    // A detected write drops the drive even with enable low.
    task automatic t_wdet;
        oeReq = 1'b1;
        load(18'h00003);
        tick(4);
        chk("dataOe", 18'h00001, {17'h0, dataOe});
        writeDetect = 1'b1;
        tick(1);
        writeDetect = 1'b0;
        chk("dataOe", 18'h00000, {17'h0, dataOe});
        chk("parityOe", 18'h00000, {17'h0, parityOe});
        oeReq = 1'b0;
        tick(4);
        rd(18'h00003, 18'h01234);
    endtask : t_wdet

    // Each single wrong select deselects the memory.
    task automatic t_sel;
        logic [8:0] badSel;
        badSel = 9'h183;
        for (int i = 0; i < 3; i++) begin
            {chipSelFirst_n, chipSelSecond, chipSelThird_n} = badSel[i*3+:3];
            tick(2);
            chk("chipSelected", 18'h0, 18'(chipSelected));
            {chipSelFirst_n, chipSelSecond, chipSelThird_n} = 3'h2;
            tick(2);
            chk("chipSelected", 18'h1, {17'h0, chipSelected});
        end
    endtask : t_sel

    task automatic t_mode;
        burstOrderSel = 1'b0;
        tick(4);
        chk("interleaveMode", 18'h0, {17'h0, interleaveMode});
        burstOrderSel = 1'b1;
        tick(4);
        chk("interleaveMode", 18'h1, {17'h0, interleaveMode});
    endtask : t_mode

    // A write while asleep is ignored and the array is kept.
    task automatic t_sleep;
        chipSelFirst_n = 1'b1;
        snoozeReq = 1'b1;
        tick(5);
        chk("sleepActive", 18'h1, {17'h0, sleepActive});
        chipSelFirst_n = 1'b0;
        wr(18'h1F0A5, 18'h00000, 2'h3);
        chipSelFirst_n = 1'b1;
        snoozeReq = 1'b0;
        tick(6);
        chk("sleepActive", 18'h0, {17'h0, sleepActive});
        chipSelFirst_n = 1'b0;
        rd(18'h1F0A5, 18'h3A53C);
    endtask : t_sleep

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Clock at 200 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // The whole run is under a hundred cycles; this is ample margin.
    initial begin
        #20000;
        failures++;
        test_done();
    end

    // Unconnected snooze and mode pins are driven at their pull levels.
    initial begin
        {reset_n, addrLoad, writeDetect, oeReq, ctlDrive} = 5'h0;
        {chipSelFirst_n, chipSelSecond, chipSelThird_n} = 3'h2;
        {snoozeReq, burstOrderSel, byteWrite} = 4'h4;
        {address, ctlWord} = 36'h0;
        tick(3);
        reset_n = 1'b1;
        tick(3);
        chk("sleepActive", 18'h0, {17'h0, sleepActive});
        chk("interleaveMode", 18'h1, {17'h0, interleaveMode});
        t_rw();
        t_wdet();
        t_sel();
        t_mode();
        t_sleep();
        test_done();
    end
endmodule : test_sbsc_pin_control
`default_nettype wire
